// ==== tb/sync_clamp_ctrl_properties.sv ====
// Purpose: Port-level checks of the sync, clamp and coast controller
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to every controller instance
`timescale 1ns/10ps
module sync_clamp_ctrl_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [sync_clamp_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [sync_clamp_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [sync_clamp_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic green_sync_in_a_i,
  input wire logic green_sync_in_b_i,
  input wire logic green_slicer_out_o,
  input wire logic [sync_clamp_pkg::THR_W-1:0] slicer_threshold_o,
  input wire logic pll_ref_pulse_o,
  input wire logic pll_coast_o,
  input wire logic ext_clock_sel_o
);
  import sync_clamp_pkg::*;
  // ==========================================================================
  // Bus handshake, clock source, sync and slicer checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("Request not answered next cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Waitrequest low too long");
  AST_READ_UPPER: assert property (!avs_waitrequest_o |-> avs_readdata_o[DATA_W-1:REG_W] == '0)
    else $error("Read data upper bits set");
  AST_EXT_CLK: assert property (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
    && avs_address_i[ADDR_W-1:2] == IDX_CLK
    |-> ##2 ext_clock_sel_o == $past(avs_writedata_i[EXTCLK_BIT], 2))
    else $error("Clock source select not taken from write");
  AST_REF_PULSE: assert property (pll_ref_pulse_o |=> !pll_ref_pulse_o)
    else $error("Reference pulse longer than one cycle");
  AST_REF_COAST: assert property (pll_coast_o [*3] |-> !pll_ref_pulse_o)
    else $error("Reference pulse while coasting");
  AST_SLICER_COPY: assert property (green_slicer_out_o
    |-> $past(green_sync_in_a_i) || $past(green_sync_in_b_i))
    else $error("Slicer output high without green input");
  AST_THR_RESET: assert property ($fell(srst_i) |-> slicer_threshold_o == RST_THR)
    else $error("Threshold code wrong after reset");
endmodule : sync_clamp_ctrl_properties

bind sync_clamp_ctrl sync_clamp_ctrl_properties u_props (
  .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .green_sync_in_a_i(green_sync_in_a_i),
  .green_sync_in_b_i(green_sync_in_b_i), .green_slicer_out_o(green_slicer_out_o),
  .slicer_threshold_o(slicer_threshold_o), .pll_ref_pulse_o(pll_ref_pulse_o),
  .pll_coast_o(pll_coast_o), .ext_clock_sel_o(ext_clock_sel_o));

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the sync, clamp and coast controller
// Assumes: Avalon-MM master with one wait state per request
// Notes: Channel A from the source model, channel B from the bench
`timescale 1ns/10ps
module tb_top;
  import sync_clamp_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0, wr = 1'b0, hs_a, vs_a, green_a, hs_inv = 1'b0, wait_n;
  logic [DATA_W-1:0] wdata = '0, rdata, q;
  logic [3:0] be = 4'hf;
  logic green_b = 1'b0, clamp_pin = 1'b0, hold_pin = 1'b0;
  logic pd_pin = 1'b0;
  logic green_out, ref_pulse, coast, clamp, field, ext_sel, pd, hs_proc;
  logic [THR_W-1:0] thr;
  int failures = 0, n_compared = 0, cycles = 0, k, g0;
  always #2.5 clk_i = ~clk_i;
  sync_clamp_ctrl u_dut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_n), .horiz_sync_in_a_i(hs_a),
    .horiz_sync_in_b_i(green_b), .vert_sync_in_a_i(vs_a), .vert_sync_in_b_i(green_b),
    .green_sync_in_a_i(green_a), .green_sync_in_b_i(green_b), .clamp_pin_i(clamp_pin),
    .shared_clock_hold_pin_i(hold_pin), .power_down_pin_i(pd_pin),
    .green_slicer_out_o(green_out), .slicer_threshold_o(thr), .horiz_sync_proc_o(hs_proc),
    .pll_ref_pulse_o(ref_pulse), .pll_coast_o(coast), .clamp_o(clamp),
    .field_odd_o(field), .ext_clock_sel_o(ext_sel), .power_down_o(pd));
  video_source_model u_src (.clk_i(clk_i), .srst_i(srst_i), .hs_inv_i(hs_inv),
    .horiz_sync_o(hs_a), .vert_sync_o(vs_a), .green_sync_o(green_a));
  // ==========================================================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wr <= we;
    rd <= !we;
    do @(posedge clk_i); while (wait_n !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task hs_to(input logic v);
    for (int i = 0; i < 2000 && hs_a !== v; i++) @(posedge clk_i);
  endtask : hs_to
  task pulses(input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (ref_pulse === 1'b1) k++;
    end
  endtask : pulses
  task report_and_stop;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Scenarios
  task t_defaults;
    bus(0, IDX_CLCO, 0); chk(q, 32'hc0);
    bus(0, IDX_CLK, 0); chk(q, 0);
    bus(0, 8'h3f, 0); chk(q, 0);
    bus(0, IDX_THR, 0); chk(q, 32'h0f);
    for (int c = 0; c < 32; c += 31) begin
      bus(1, IDX_THR, c[7:0]); cyc(2); chk(thr, c);
    end
    $display("t_defaults done");
  endtask : t_defaults
  task t_hsync;
    for (int i = 0; i < 3; i++) begin
      hs_inv <= (i != 1);
      bus(1, IDX_HPOL, i == 0 ? 8'h20 : i == 1 ? 8'h30 : 8'h00);
      cyc(i == 2 ? 4000 : 400);
      for (k = 0; k < 1000 && ref_pulse !== 1'b1; k++) @(posedge clk_i);
      chk(hs_a, i == 1);
      chk(hs_proc, 1);
    end
    hs_inv <= 1'b0;
    bus(1, IDX_HPOL, 8'h30);
    $display("t_hsync done");
  endtask : t_hsync
  task t_coast_clock;
    bus(1, IDX_CLK, 8'h04); cyc(2); chk(ext_sel, 1);
    hold_pin <= 1'b1; cyc(4); chk(coast, 1); chk(ext_sel, 1);
    pulses(400); chk(k, 0);
    hold_pin <= 1'b0; pulses(400); chk(k > 0, 1);
    for (k = 0; k < 2000 && vs_a !== 1'b0; k++) @(posedge clk_i);
    for (k = 0; k < 2000 && vs_a !== 1'b1; k++) @(posedge clk_i);
    cyc(3); chk(coast, 1); chk(field, 1);
    bus(1, IDX_CLK, 8'h00); cyc(2); chk(ext_sel, 0);
    $display("t_coast_clock done");
  endtask : t_coast_clock
  task t_clamp_int;
    clamp_pin <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      bus(1, IDX_CLDLY, i ? 8'h06 : 8'h02);
      bus(1, IDX_CLDUR, i ? 8'h05 : 8'h03);
      hs_to(1'b1); hs_to(1'b0);
      for (k = 0; k < 300 && clamp !== 1'b1; k++) @(posedge clk_i);
      if (i) chk(k - g0, 4);
      g0 = k;
      for (k = 0; k < 300 && clamp === 1'b1; k++) @(posedge clk_i);
      chk(k, i ? 6 : 4);
    end
    $display("t_clamp_int done");
  endtask : t_clamp_int
  task t_clamp_ext;
    bus(1, IDX_CLCO, 8'hd0);
    for (int i = 0; i < 2; i++) begin
      bus(1, IDX_CLPOL, i ? 8'h80 : 8'hc0);
      for (int p = 0; p < 2; p++) begin
        clamp_pin <= p[0]; cyc(3); chk(clamp, p[0] ^ i[0]);
      end
    end
    bus(1, IDX_CLCO, 8'hc0);
    $display("t_clamp_ext done");
  endtask : t_clamp_ext
  task t_power;
    for (int i = 0; i < 5; i++) begin
      bus(1, IDX_PWR, i < 2 ? 8'h14 : i < 4 ? 8'h10 : 8'h04);
      pd_pin <= (i == 0 || i == 3 || i == 4);
      cyc(3); chk(pd, i == 0 || i == 2);
    end
    pd_pin <= 1'b0;
    $display("t_power done");
  endtask : t_power
  task t_route;
    bus(1, IDX_ROUTE, 8'h01);
    for (int p = 0; p < 2; p++) begin
      green_b <= p[0]; cyc(3); chk(green_out, p); chk(hs_proc, p); chk(coast, p);
    end
    bus(1, IDX_ROUTE, 8'h03); cyc(1700); chk(hs_proc, 0); chk(coast, 1);
    bus(1, IDX_ROUTE, 8'h00);
    hs_to(1'b0); hs_to(1'b1); cyc(3); chk(green_out, 1);
    cyc(40); chk(green_out, 0);
    $display("t_route done");
  endtask : t_route
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    cyc(12);
    srst_i <= 1'b0;
    cyc(1);
    t_defaults;
    bus(1, IDX_VPOL, 8'h30);
    t_hsync;
    t_coast_clock;
    t_clamp_int;
    t_clamp_ext;
    t_power;
    t_route;
    report_and_stop;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop;
    end
  end
endmodule : tb_top

// ==== tb/video_source_model.sv ====
// Purpose: Video source driving horizontal, vertical and green sync
// Assumes: Pins change just after the rising clock edge
// Notes: Horizontal pulse active high unless hs_inv_i is set
`timescale 1ns/10ps
module video_source_model #(
  parameter int LINE = 200,  // Cycles per line
  parameter int HS_W = 20,   // Horizontal pulse width
  parameter int FRAME = 8    // Lines per frame
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hs_inv_i,
  output logic horiz_sync_o,
  output logic vert_sync_o,
  output logic green_sync_o
);
  int pos_ff;
  int line_ff;
  // ==========================================================================
  // Line and frame position
  always @(posedge clk_i) begin
    if (srst_i || pos_ff == LINE - 1) begin
      pos_ff <= 0;
    end else begin
      pos_ff <= pos_ff + 1;
    end
    if (srst_i) begin
      line_ff <= 0;
    end else if (pos_ff == LINE - 1) begin
      line_ff <= (line_ff == FRAME - 1) ? 0 : line_ff + 1;
    end
  end
  // Pulse at line start, vertical over the first line of a frame
  assign horiz_sync_o = (pos_ff < HS_W) ^ hs_inv_i;
  assign vert_sync_o = (line_ff == 0);
  assign green_sync_o = horiz_sync_o;
endmodule : video_source_model

// ==== verilog/sync_clamp_ctrl.sv ====
// Purpose: Sync polarity, clamp, coast and clock-source control
// Assumes: All pins synchronous to clk_i; Avalon-MM slave with waitrequest
// Notes:   Every output is registered
`timescale 1ns/10ps
module sync_clamp_ctrl (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [sync_clamp_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [sync_clamp_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [sync_clamp_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic horiz_sync_in_a_i,
  input wire logic horiz_sync_in_b_i,
  input wire logic vert_sync_in_a_i,
  input wire logic vert_sync_in_b_i,
  input wire logic green_sync_in_a_i,
  input wire logic green_sync_in_b_i,
  input wire logic clamp_pin_i,
  input wire logic shared_clock_hold_pin_i,
  input wire logic power_down_pin_i,
  output logic green_slicer_out_o,
  output logic [sync_clamp_pkg::THR_W-1:0] slicer_threshold_o,
  output logic horiz_sync_proc_o,
  output logic pll_ref_pulse_o,
  output logic pll_coast_o,
  output logic clamp_o,
  output logic field_odd_o,
  output logic ext_clock_sel_o,
  output logic power_down_o
);
  import sync_clamp_pkg::*;

  // ==========================================================================
  // State record
  typedef struct packed {
    logic [REG_W-1:0] r_clk;                   // Clock source register
    logic [REG_W-1:0] r_hpol;                  // Hsync polarity register
    logic [REG_W-1:0] r_vpol;                  // Vsync polarity register
    logic [REG_W-1:0] r_clco;                  // Coast/clamp enable register
    logic [REG_W-1:0] r_clpol;                 // Clamp polarity register
    logic [REG_W-1:0] r_pwr;                   // Power-down register
    logic [REG_W-1:0] r_route;                 // Routing register
    logic [THR_W-1:0] r_thr;                   // Threshold code
    logic [REG_W-1:0] r_cldly;                 // Clamp delay count
    logic [REG_W-1:0] r_cldur;                 // Clamp duration count
    logic wait_n;                              // Low for the answer cycle
    logic [DATA_W-1:0] rdata;                  // Read data
    logic hs_q;                                // Previous normalized hsync
    logic vs_q;                                // Previous normalized vsync
    logic cs_q;                                // Previous composite level
    logic [CNT_W-1:0] cs_cnt;                  // Composite pulse width
    logic sep_vs;                              // Separated vertical sync
    logic [CNT_W-1:0] line_cnt;                // Cycles since hsync lead
    logic [CNT_W-1:0] line_len;                // Last line length
    clamp_state_t cl_state;                    // Internal clamp state
    logic [REG_W-1:0] cl_cnt;                  // Clamp counter
    logic clamp;
    logic coast;
    logic pll_ref;
    logic field_odd;
    logic green_out;
    logic hs_out;
    logic ext_sel;
    logic pwr_dn;
  } ctrl_st_t;

  ctrl_st_t st_ff;
  ctrl_st_t nxt_st;

  // ==========================================================================
  // Input routing and polarity detectors
  logic hs_raw;                                // Selected hsync pin
  logic vs_raw;                                // Selected vsync pin
  logic sog_raw;                               // Selected slicer output
  logic sog_mode;                              // Sync taken from green
  logic [DET_N-1:0] det_in;                    // Detector inputs
  logic [DET_N-1:0] det_low;                   // Detector verdicts

  assign sog_mode = st_ff.r_route[ROUTE_SOG_BIT];
  // Channel pair select
  assign hs_raw = st_ff.r_route[ROUTE_CH_BIT] ? horiz_sync_in_b_i : horiz_sync_in_a_i;
  assign vs_raw = st_ff.r_route[ROUTE_CH_BIT] ? vert_sync_in_b_i : vert_sync_in_a_i;
  assign sog_raw = st_ff.r_route[ROUTE_CH_BIT] ? green_sync_in_b_i : green_sync_in_a_i;

  // Composite from green replaces hsync; separated vertical replaces vsync
  assign det_in[DET_HS] = sog_mode ? sog_raw : hs_raw;
  assign det_in[DET_VS] = sog_mode ? st_ff.sep_vs : vs_raw;
  assign det_in[DET_CL] = clamp_pin_i;
  assign det_in[DET_CO] = shared_clock_hold_pin_i;

  // One detector per sync-like input
  generate
    for (genvar gi = 0; gi < DET_N; gi++) begin : g_det
      sync_polarity_detect #(
        .BAL_W(12)
      ) u_det (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sig_i(det_in[gi]),
        .active_low_o(det_low[gi])
      );
    end
  endgenerate

  // Active sense: 1 means active high (rising edge), 0 active low
  logic hs_pol;
  logic vs_pol;
  logic cl_pol;
  logic co_pol;
  logic hs_n;                                  // Normalized, active high
  logic vs_n;
  logic cl_n;
  logic co_n;

  // Manual bit picks register value, else detector
  assign hs_pol = st_ff.r_hpol[SYNC_MAN_BIT] ? st_ff.r_hpol[SYNC_VAL_BIT] : ~det_low[DET_HS];
  assign vs_pol = st_ff.r_vpol[SYNC_MAN_BIT] ? st_ff.r_vpol[SYNC_VAL_BIT] : ~det_low[DET_VS];
  assign cl_pol = st_ff.r_clpol[CLPOL_MAN_BIT] ? st_ff.r_clpol[CLPOL_VAL_BIT]
                                               : ~det_low[DET_CL];
  assign co_pol = st_ff.r_clco[COAST_MAN_BIT] ? st_ff.r_clco[COAST_VAL_BIT] : ~det_low[DET_CO];

  // Polarity 0 inverts so the falling edge becomes the active one
  assign hs_n = hs_pol ? det_in[DET_HS] : ~det_in[DET_HS];
  assign vs_n = vs_pol ? det_in[DET_VS] : ~det_in[DET_VS];
  assign cl_n = cl_pol ? clamp_pin_i : ~clamp_pin_i;
  assign co_n = co_pol ? shared_clock_hold_pin_i : ~shared_clock_hold_pin_i;

  // ==========================================================================
  // Bus decode
  logic [7:0] idx;                             // Register index
  logic req;                                   // Request seen
  logic wr_take;                               // Write takes effect now
  logic wr_lane;                               // Low byte lane enabled

  assign idx = avs_address_i[ADDR_W-1:2];
  assign req = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ~st_ff.wait_n & avs_byteenable_i[0];
  assign wr_lane = wr_take;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic hs_lead;
    logic hs_trail;
    logic vs_lead;
    logic cs_lvl;
    logic [REG_W-1:0] wb;
    hs_lead = 1'b0;
    hs_trail = 1'b0;
    vs_lead = 1'b0;
    cs_lvl = 1'b0;
    wb = avs_writedata_i[REG_W-1:0];
    nxt_st = st_ff;

    // Waitrequest drops for one cycle after a request is seen
    if (req && st_ff.wait_n && !(!st_ff.wait_n)) begin
      nxt_st.wait_n = 1'b0;
    end else begin
      nxt_st.wait_n = 1'b1;
    end
    if (!st_ff.wait_n) begin
      nxt_st.wait_n = 1'b1;                    // Release after the answer
    end

    // Read data loaded one edge before waitrequest is sampled low
    nxt_st.rdata = '0;
    if (avs_read_i && st_ff.wait_n) begin
      case (idx)
        IDX_CLK: nxt_st.rdata[REG_W-1:0] = st_ff.r_clk;
        IDX_HPOL: nxt_st.rdata[REG_W-1:0] = st_ff.r_hpol;
        IDX_VPOL: nxt_st.rdata[REG_W-1:0] = st_ff.r_vpol;
        IDX_CLCO: nxt_st.rdata[REG_W-1:0] = st_ff.r_clco;
        IDX_CLPOL: nxt_st.rdata[REG_W-1:0] = st_ff.r_clpol;
        IDX_PWR: nxt_st.rdata[REG_W-1:0] = st_ff.r_pwr;
        IDX_ROUTE: nxt_st.rdata[REG_W-1:0] = st_ff.r_route;
        IDX_THR: nxt_st.rdata[THR_W-1:0] = st_ff.r_thr;
        IDX_STAT: nxt_st.rdata[REG_W-1:0] = {2'b00, st_ff.coast, st_ff.field_odd,
                                             det_low[DET_CO], det_low[DET_CL],
                                             det_low[DET_VS], det_low[DET_HS]};
        IDX_CLDLY: nxt_st.rdata[REG_W-1:0] = st_ff.r_cldly;
        IDX_CLDUR: nxt_st.rdata[REG_W-1:0] = st_ff.r_cldur;
        default: nxt_st.rdata = '0;            // Unmapped reads as zero
      endcase
    end else if (!st_ff.wait_n) begin
      nxt_st.rdata = st_ff.rdata;              // Hold through the answer edge
    end

    // Register writes; unmapped addresses ignored
    if (wr_lane) begin
      case (idx)
        IDX_CLK: nxt_st.r_clk = wb;
        IDX_HPOL: nxt_st.r_hpol = wb;
        IDX_VPOL: nxt_st.r_vpol = wb;
        IDX_CLCO: nxt_st.r_clco = wb;
        IDX_CLPOL: nxt_st.r_clpol = wb;
        IDX_PWR: nxt_st.r_pwr = wb;
        IDX_ROUTE: nxt_st.r_route = wb;
        IDX_THR: nxt_st.r_thr = wb[THR_W-1:0];
        IDX_CLDLY: nxt_st.r_cldly = wb;
        IDX_CLDUR: nxt_st.r_cldur = wb;
        default: nxt_st.r_clk = st_ff.r_clk;
      endcase
    end

    // Composite separation: long pulses are vertical
    cs_lvl = hs_n;
    nxt_st.cs_q = cs_lvl;
    if (cs_lvl) begin
      if (st_ff.cs_cnt != SEP_CYCLES) begin
        nxt_st.cs_cnt = st_ff.cs_cnt + 1'b1;
      end else begin
        nxt_st.sep_vs = 1'b1;
      end
    end else begin
      nxt_st.cs_cnt = '0;
      nxt_st.sep_vs = 1'b0;
    end

    // Horizontal edges; vertical interval masked in green mode
    hs_lead = hs_n & ~st_ff.hs_q & ~(sog_mode & st_ff.sep_vs);
    hs_trail = ~hs_n & st_ff.hs_q & ~(sog_mode & st_ff.sep_vs);
    nxt_st.hs_q = hs_n;
    nxt_st.hs_out = hs_n & ~(sog_mode & st_ff.sep_vs);
    vs_lead = vs_n & ~st_ff.vs_q;
    nxt_st.vs_q = vs_n;

    // Line length tracking for field decision
    if (hs_lead) begin
      nxt_st.line_len = st_ff.line_cnt;
      nxt_st.line_cnt = '0;
    end else if (st_ff.line_cnt != '1) begin
      nxt_st.line_cnt = st_ff.line_cnt + 1'b1;
    end

    // Odd field when vsync lands in second half of the line
    if (vs_lead) begin
      nxt_st.field_odd = (st_ff.line_cnt > (st_ff.line_len >> 1));
    end

    // Coast from pin or vsync, regardless of clock source
    nxt_st.coast = co_n | vs_n;

    // Clock generator reference only on lead edge, held off while coasting
    nxt_st.pll_ref = hs_lead & ~(co_n | vs_n);

    // Internal clamp sequencer timed from trailing edge
    case (st_ff.cl_state)
      CL_IDLE: begin
        if (hs_trail) begin
          nxt_st.cl_state = CL_DELAY;
          nxt_st.cl_cnt = st_ff.r_cldly;
        end
      end
      CL_DELAY: begin
        if (st_ff.cl_cnt == '0) begin
          nxt_st.cl_state = CL_ON;
          nxt_st.cl_cnt = st_ff.r_cldur;
        end else begin
          nxt_st.cl_cnt = st_ff.cl_cnt - 1'b1;
        end
      end
      CL_ON: begin
        if (st_ff.cl_cnt == '0) begin
          nxt_st.cl_state = CL_IDLE;
        end else begin
          nxt_st.cl_cnt = st_ff.cl_cnt - 1'b1;
        end
      end
      default: nxt_st.cl_state = CL_IDLE;
    endcase

    // External pin only when enabled, else internal window
    if (st_ff.r_clco[CLAMP_EN_BIT]) begin
      nxt_st.clamp = cl_n;
    end else begin
      nxt_st.clamp = (st_ff.cl_state == CL_ON);
    end

    // Clock source select; does not touch coast path
    nxt_st.ext_sel = st_ff.r_clk[EXTCLK_BIT];

    // Manual power-down with programmable pin sense
    nxt_st.pwr_dn = st_ff.r_pwr[PD_SEL_BIT] &
                    (st_ff.r_pwr[PD_POL_BIT] ? power_down_pin_i : ~power_down_pin_i);

    // Slicer output passed through non-inverted
    nxt_st.green_out = sog_raw;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.r_clk <= RST_CLK;
      st_ff.r_hpol <= RST_HPOL;
      st_ff.r_vpol <= RST_VPOL;
      st_ff.r_clco <= RST_CLCO;                // Coast polarity 1, internal clamp
      st_ff.r_clpol <= RST_CLPOL;
      st_ff.r_pwr <= RST_PWR;
      st_ff.r_route <= RST_ROUTE;
      st_ff.r_thr <= RST_THR;                  // 128 mV default
      st_ff.r_cldly <= RST_CLDLY;
      st_ff.r_cldur <= RST_CLDUR;
      st_ff.wait_n <= 1'b1;
      st_ff.cl_state <= CL_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.wait_n;
  assign green_slicer_out_o = st_ff.green_out;
  assign slicer_threshold_o = st_ff.r_thr;     // (code + 1) * 8 mV
  assign horiz_sync_proc_o = st_ff.hs_out;
  assign pll_ref_pulse_o = st_ff.pll_ref;
  assign pll_coast_o = st_ff.coast;
  assign clamp_o = st_ff.clamp;
  assign field_odd_o = st_ff.field_odd;
  assign ext_clock_sel_o = st_ff.ext_sel;
  assign power_down_o = st_ff.pwr_dn;

endmodule : sync_clamp_ctrl

// ==== verilog/sync_clamp_pkg.sv ====
// Purpose: Shared constants for the sync, clamp and coast input controller
// Assumes: 200 MHz system clock, registers reached over Avalon-MM
// Notes:   Register byte address is four times the register index
package sync_clamp_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 10;                  // Byte address width
  localparam int DATA_W = 32;                  // Bus data width
  localparam int REG_W = 8;                    // Stored register width

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CLK = 8'h03;      // Clock source control
  localparam logic [7:0] IDX_HPOL = 8'h12;     // Horizontal sync polarity
  localparam logic [7:0] IDX_VPOL = 8'h14;     // Vertical sync polarity
  localparam logic [7:0] IDX_CLCO = 8'h18;     // Coast polarity, clamp enable
  localparam logic [7:0] IDX_CLPOL = 8'h1b;    // Clamp polarity
  localparam logic [7:0] IDX_PWR = 8'h1e;      // Power-down pin control
  localparam logic [7:0] IDX_ROUTE = 8'h20;    // Channel and sync source
  localparam logic [7:0] IDX_THR = 8'h21;      // Slicer threshold code
  localparam logic [7:0] IDX_STAT = 8'h22;     // Read-only status
  localparam logic [7:0] IDX_CLDLY = 8'h23;    // Internal clamp delay
  localparam logic [7:0] IDX_CLDUR = 8'h24;    // Internal clamp duration

  // ==========================================================================
  // Field positions
  localparam int EXTCLK_BIT = 2;               // External pixel clock enable
  localparam int SYNC_MAN_BIT = 5;             // Sync polarity manual select
  localparam int SYNC_VAL_BIT = 4;             // Sync polarity value
  localparam int COAST_MAN_BIT = 7;            // Coast polarity manual select
  localparam int COAST_VAL_BIT = 6;            // Coast polarity value
  localparam int CLAMP_EN_BIT = 4;             // External clamp enable
  localparam int CLPOL_MAN_BIT = 7;            // Clamp polarity manual select
  localparam int CLPOL_VAL_BIT = 6;            // Clamp polarity value
  localparam int PD_SEL_BIT = 4;               // Manual power-down select
  localparam int PD_POL_BIT = 2;               // Power-down pin polarity
  localparam int ROUTE_CH_BIT = 0;             // Input channel select
  localparam int ROUTE_SOG_BIT = 1;            // Take sync from green slicer

  // Detector slots
  localparam int DET_HS = 0;
  localparam int DET_VS = 1;
  localparam int DET_CL = 2;
  localparam int DET_CO = 3;
  localparam int DET_N = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CLK = 8'h00;
  localparam logic [7:0] RST_HPOL = 8'h00;
  localparam logic [7:0] RST_VPOL = 8'h00;
  localparam logic [7:0] RST_CLCO = 8'hc0;     // Coast manual, polarity 1
  localparam logic [7:0] RST_CLPOL = 8'h00;
  localparam logic [7:0] RST_PWR = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_CLDLY = 8'h08;
  localparam logic [7:0] RST_CLDUR = 8'h10;

  // Slicer threshold: millivolts = (code + 1) * step
  localparam int THR_W = 5;
  localparam int THR_STEP_MV = 8;
  localparam int THR_DEFAULT_MV = 128;
  localparam logic [THR_W-1:0] RST_THR = THR_W'(THR_DEFAULT_MV / THR_STEP_MV - 1);

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SEP_TIME_NS = 8000;           // Composite pulse longer = vertical
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SEP_CYCLES = CNT_W'((SEP_TIME_NS + CLK_PERIOD_NS - 1)
                                                   / CLK_PERIOD_NS);

  // ==========================================================================
  // Internal clamp sequencer
  typedef enum logic [1:0] {
    CL_IDLE = 2'b00,
    CL_DELAY = 2'b01,
    CL_ON = 2'b10
  } clamp_state_t;

endpackage : sync_clamp_pkg

// ==== verilog/sync_polarity_detect.sv ====
// Purpose: Guess the active sense of one sync-like input
// Assumes: Input is synchronous to clk_i
// Notes:   Mostly high means active low; output is registered
`timescale 1ns/10ps
module sync_polarity_detect #(
  parameter int BAL_W = 12                     // Balance counter width
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sig_i,
  output logic active_low_o
);
  import sync_clamp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic signed [BAL_W-1:0] bal;              // High minus low balance
    logic act_low;                             // Registered verdict
  } det_st_t;

  localparam logic signed [BAL_W-1:0] BAL_MAX = {1'b0, {(BAL_W-1){1'b1}}};
  localparam logic signed [BAL_W-1:0] BAL_MIN = {1'b1, {(BAL_W-1){1'b0}}};

  det_st_t st_ff;
  det_st_t nxt_st;

  // Saturating up/down count of high versus low time
  always_comb begin
    nxt_st = st_ff;
    if (sig_i) begin
      if (st_ff.bal != BAL_MAX) begin
        nxt_st.bal = st_ff.bal + 1'b1;
      end
    end else begin
      if (st_ff.bal != BAL_MIN) begin
        nxt_st.bal = st_ff.bal - 1'b1;
      end
    end
    nxt_st.act_low = (st_ff.bal > 0);          // Mostly high
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active_low_o = st_ff.act_low;

endmodule : sync_polarity_detect
